// [rbs_exec.sv]
// Notes on behaviour
// RULE1 - Decode memory rotate-through-extend word, direction bit
// RULE2 - Rotate accepts memory alterable addressing modes only
// RULE3 - Word rotates one bit through extend
// RULE4 - Rotate sets X,C out, N,Z result, V clear
// RULE5 - Deallocate return: pop PC, add 4+disp
// RULE6 - Exception return traps unless supervisor; pops SR,PC
// RULE7 - Frame word: format in 15-12, offset below
// RULE8 - Format 0000 removes four words, loads SR,PC
// RULE9 - Format 0001 loads SR, continues on new stack
// RULE10 - Format 0010 removes six words
// RULE11 - Format 1001 removes ten words, resumes
// RULE12 - Formats 1010/1011 remove 16/46 words, resume
// RULE13 - Other formats take format error exception
// RULE14 - Flag return pops CONDITION_CODE_BYTE word then PC
// RULE15 - Subroutine return pops PC, SP plus 4
// RULE16 - Decimal subtract dest minus source minus X
// RULE17 - Decimal subtract encoding, register or predecrement memory
// RULE18 - Decimal subtract flags: borrow, sticky Z
// RULE19 - Set-on-condition writes ones or zeros byte
// RULE20 - Condition codes 0000 to 0111
// RULE21 - Condition codes 1000 to 1111
// RULE22 - Set-on-condition encoding, data alterable, flags kept
// RULE23 - Word pops for flags, long pops for PC
//
// The register offsets and the plain strobed port were chosen for this implementation.
`include "rbs_map.svh"

module rbs_exec
  import rbs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [15:0] instr_ext,
  input wire logic [31:0] ea_addr,
  input wire logic [31:0] reg_src,
  input wire logic [31:0] reg_dst,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output rbs_mem_t mem,
  output rbs_rf_t rf,
  output logic an_we,
  output logic [31:0] an_src,
  output logic [31:0] an_dst,
  output logic [31:0] pc,
  output logic [31:0] stack_pointer,
  output logic [15:0] status_word,
  output logic busy,
  output logic illegal,
  output logic priv_trap,
  output logic fmt_err,
  output logic resume
);

  rbs_state_t q;
  rbs_state_t d;

  ////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic rbs_mem_t mreq(input logic we, input logic [1:0] sz,
                                    input logic [31:0] a, input logic [31:0] wd);
    rbs_mem_t m;
    m.req = 1'b1;
    m.we = we;
    m.size = sz;
    m.addr = a;
    m.wdata = wd;
    return m;
  endfunction : mreq

  function automatic logic cond_true(input logic [3:0] cc, input logic [15:0] s);
    logic c;
    logic v;
    logic z;
    logic n;
    logic t;
    c = s[`RBS_BIT_C];
    v = s[`RBS_BIT_V];
    z = s[`RBS_BIT_Z];
    n = s[`RBS_BIT_N];
    case (cc)
      4'h0: t = 1'b1; // RULE20
      4'h1: t = 1'b0; // RULE20
      4'h2: t = !c && !z; // RULE20
      4'h3: t = c || z; // RULE20
      4'h4: t = !c; // RULE20
      4'h5: t = c; // RULE20
      4'h6: t = !z; // RULE20
      4'h7: t = z; // RULE20
      4'h8: t = !v; // RULE21
      4'h9: t = v; // RULE21
      4'ha: t = !n; // RULE21
      4'hb: t = n; // RULE21
      4'hc: t = (n == v); // RULE21
      4'hd: t = (n != v); // RULE21
      4'he: t = (n == v) && !z; // RULE21
      default: t = z || (n != v); // RULE21
    endcase
    return t;
  endfunction : cond_true

  // Returns {borrow, result}
  function automatic logic [8:0] bcd_sub(input logic [7:0] a, input logic [7:0] b,
                                         input logic x);
    logic [4:0] lo;
    logic [9:0] r;
    logic br;
    lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, x};
    r = {2'h0, a} - {2'h0, b} - {9'h000, x}; // RULE16
    if (lo[4]) begin
      r = r - 10'h006;
    end
    br = r[9];
    if (br) begin
      r = r - 10'h060;
    end
    return {br, r[7:0]};
  endfunction : bcd_sub

  function automatic logic [5:0] fmt_words(input logic [3:0] f);
    logic [5:0] w;
    case (f)
      `RBS_FMT_SHORT: w = `RBS_W_SHORT; // RULE8
      `RBS_FMT_THROW: w = `RBS_W_THROW; // RULE9
      `RBS_FMT_INSTERR: w = `RBS_W_INSTERR; // RULE10
      `RBS_FMT_COPRO: w = `RBS_W_COPRO; // RULE11
      `RBS_FMT_MID: w = `RBS_W_MID; // RULE12
      `RBS_FMT_LONG: w = `RBS_W_LONG; // RULE12
      default: w = 6'h00; // RULE13
    endcase
    return w;
  endfunction : fmt_words

  ////////////////////////////////////////////////////////////////////
  // Decode fields

  logic [2:0] ea_mode;
  logic [2:0] ea_reg;
  logic mem_alt;
  logic data_alt;
  logic is_rot;
  logic is_setc;
  logic is_dsub;
  logic [8:0] bcd_r;
  logic [15:0] rot_v;
  logic [15:0] rot_res;
  logic rot_out;
  logic [5:0] words;

  always_comb begin
    ea_mode = instr_word[5:3];
    ea_reg = instr_word[2:0];
    mem_alt = (ea_mode >= 3'h2 && ea_mode <= 3'h6) ||
              (ea_mode == 3'h7 && ea_reg <= 3'h1); // RULE2
    data_alt = mem_alt || ea_mode == 3'h0; // RULE22
    is_rot = instr_word[15:9] == `RBS_ROT_TOP &&
             instr_word[7:6] == 2'h3; // RULE1
    is_setc = instr_word[15:12] == `RBS_SETC_TOP &&
              instr_word[7:6] == 2'h3; // RULE22
    is_dsub = instr_word[15:12] == `RBS_DSUB_TOP && instr_word[8] &&
              instr_word[7:4] == 4'h0; // RULE17
  end

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    d.rf.we = 1'b0;
    d.an_we = 1'b0;
    d.illegal = 1'b0;
    d.priv_trap = 1'b0;
    d.fmt_err = 1'b0;
    d.resume = 1'b0;
    if (mem_ack) begin
      d.mem.req = 1'b0;
    end
    bcd_r = 9'h000;
    rot_v = mem_rdata[15:0];
    rot_res = 16'h0000;
    rot_out = 1'b0;
    words = fmt_words(mem_rdata[15:12]); // RULE7
    case (q.st)
      ST_IDLE: begin
        if (instr_valid) begin
          d.ir = instr_word;
          d.disp = instr_ext;
          d.ea = ea_addr;
          d.busy = 1'b1;
          if (is_rot && mem_alt) begin
            d.op = OP_ROTX;
            d.st = ST_RD_OP;
            d.mem = mreq(1'b0, `RBS_SZ_WORD, ea_addr, 32'h0); // RULE3
          end else if (is_setc && data_alt) begin
            d.op = OP_SETC;
            if (ea_mode == 3'h0) begin
              d.rf.we = 1'b1;
              d.rf.idx = ea_reg;
              d.rf.data = {8{cond_true(instr_word[11:8], q.sr)}}; // RULE19
              d.busy = 1'b0;
            end else begin
              d.st = ST_WR_OP;
              d.mem = mreq(1'b1, `RBS_SZ_BYTE, ea_addr,
                           {24'h0, {8{cond_true(instr_word[11:8], q.sr)}}}); // RULE19
            end
          end else if (is_dsub) begin
            d.op = OP_DSUB;
            if (!instr_word[3]) begin
              bcd_r = bcd_sub(reg_dst[7:0], reg_src[7:0], q.sr[`RBS_BIT_X]); // RULE17
              d.rf.we = 1'b1;
              d.rf.idx = instr_word[11:9];
              d.rf.data = bcd_r[7:0];
              d.sr[`RBS_BIT_C] = bcd_r[8]; // RULE18
              d.sr[`RBS_BIT_X] = bcd_r[8]; // RULE18
              if (bcd_r[7:0] != 8'h00) begin
                d.sr[`RBS_BIT_Z] = 1'b0; // RULE18
              end
              d.busy = 1'b0;
            end else begin
              // Predecrement both pointers up front
              d.an_src = reg_src - 32'h1; // RULE17
              d.an_dst = reg_dst - 32'h1; // RULE17
              d.st = ST_RD_SRC;
              d.mem = mreq(1'b0, `RBS_SZ_BYTE, reg_src - 32'h1, 32'h0);
            end
          end else if (instr_word == `RBS_OP_SUB_RET) begin
            d.op = OP_SUBR;
            d.st = ST_POP_PC;
            d.mem = mreq(1'b0, `RBS_SZ_LONG, q.sp, 32'h0); // RULE15 RULE23
          end else if (instr_word == `RBS_OP_DEALLOC) begin
            d.op = OP_DEALLOC;
            d.st = ST_POP_PC;
            d.mem = mreq(1'b0, `RBS_SZ_LONG, q.sp, 32'h0); // RULE5
          end else if (instr_word == `RBS_OP_FLAG_RET) begin
            d.op = OP_FLAGS;
            d.st = ST_POP_SR;
            d.mem = mreq(1'b0, `RBS_SZ_WORD, q.sp, 32'h0); // RULE14 RULE23
          end else if (instr_word == `RBS_OP_EXC_RET) begin
            d.op = OP_EXC;
            if (q.sr[`RBS_BIT_S]) begin
              d.st = ST_POP_SR;
              d.mem = mreq(1'b0, `RBS_SZ_WORD, q.sp, 32'h0); // RULE6 RULE23
            end else begin
              d.priv_trap = 1'b1; // RULE6
              d.busy = 1'b0;
            end
          end else begin
            d.illegal = 1'b1; // RULE2
            d.busy = 1'b0;
          end
        end
      end
      ST_RD_SRC: begin
        if (mem_ack) begin
          d.src = mem_rdata[7:0];
          d.st = ST_RD_OP;
          d.mem = mreq(1'b0, `RBS_SZ_BYTE, q.an_dst, 32'h0);
        end
      end
      ST_RD_OP: begin
        if (mem_ack) begin
          d.st = ST_WR_OP;
          if (q.op == OP_ROTX) begin
            if (q.ir[8]) begin
              rot_res = {rot_v[14:0], q.sr[`RBS_BIT_X]}; // RULE3
              rot_out = rot_v[15];
            end else begin
              rot_res = {q.sr[`RBS_BIT_X], rot_v[15:1]}; // RULE3
              rot_out = rot_v[0];
            end
            d.sr[`RBS_BIT_X] = rot_out; // RULE4
            d.sr[`RBS_BIT_C] = rot_out; // RULE4
            d.sr[`RBS_BIT_N] = rot_res[15]; // RULE4
            d.sr[`RBS_BIT_Z] = rot_res == 16'h0000; // RULE4
            d.sr[`RBS_BIT_V] = 1'b0; // RULE4
            d.mem = mreq(1'b1, `RBS_SZ_WORD, q.ea, {16'h0, rot_res});
          end else begin
            bcd_r = bcd_sub(mem_rdata[7:0], q.src, q.sr[`RBS_BIT_X]); // RULE16
            d.sr[`RBS_BIT_C] = bcd_r[8]; // RULE18
            d.sr[`RBS_BIT_X] = bcd_r[8]; // RULE18
            if (bcd_r[7:0] != 8'h00) begin
              d.sr[`RBS_BIT_Z] = 1'b0; // RULE18
            end
            d.an_we = 1'b1;
            d.mem = mreq(1'b1, `RBS_SZ_BYTE, q.an_dst, {24'h0, bcd_r[7:0]});
          end
        end
      end
      ST_WR_OP: begin
        if (mem_ack) begin
          d.st = ST_IDLE;
          d.busy = 1'b0;
        end
      end
      ST_POP_SR: begin
        if (mem_ack) begin
          if (q.op == OP_FLAGS) begin
            // Only the flag byte is taken; supervisor half stays
            d.tmp_sr = {q.sr[15:8], mem_rdata[7:0]}; // RULE14
          end else begin
            d.tmp_sr = mem_rdata[15:0]; // RULE6
          end
          d.st = ST_POP_PC;
          d.mem = mreq(1'b0, `RBS_SZ_LONG, q.sp + `RBS_OFS_PC, 32'h0); // RULE23
        end
      end
      ST_POP_PC: begin
        if (mem_ack) begin
          d.st = ST_IDLE;
          d.busy = 1'b0;
          case (q.op)
            OP_SUBR: begin
              d.pc = mem_rdata; // RULE15
              d.sp = q.sp + `RBS_LEN_PC; // RULE15
            end
            OP_DEALLOC: begin
              d.pc = mem_rdata; // RULE5
              d.sp = q.sp + `RBS_LEN_PC + {{16{q.disp[15]}}, q.disp}; // RULE5
            end
            OP_FLAGS: begin
              d.pc = mem_rdata; // RULE14
              d.sr = q.tmp_sr; // RULE14
              d.sp = q.sp + `RBS_LEN_FLAGRET; // RULE14
            end
            default: begin
              // Held back until the frame format is known to be good
              d.ea = mem_rdata;
              d.st = ST_POP_FMT;
              d.busy = 1'b1;
              d.mem = mreq(1'b0, `RBS_SZ_WORD, q.sp + `RBS_OFS_FMT, 32'h0); // RULE7
            end
          endcase
        end
      end
      ST_POP_FMT: begin
        if (mem_ack) begin
          d.st = ST_IDLE;
          d.busy = 1'b0;
          if (words == 6'h00) begin
            d.fmt_err = 1'b1; // RULE13
          end else if (mem_rdata[15:12] == `RBS_FMT_THROW) begin
            d.sr = q.tmp_sr; // RULE9
            d.sp = q.sp + {25'h0, words, 1'b0}; // RULE9
            d.st = ST_POP_SR;
            d.busy = 1'b1;
            d.mem = mreq(1'b0, `RBS_SZ_WORD, q.sp + {25'h0, words, 1'b0}, 32'h0); // RULE9
          end else begin
            d.sr = q.tmp_sr; // RULE6 RULE8 RULE10
            d.pc = q.ea; // RULE8 RULE10
            d.sp = q.sp + {25'h0, words, 1'b0}; // RULE8 RULE10 RULE11 RULE12
            d.resume = mem_rdata[15]; // RULE11 RULE12
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
        d.busy = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.op <= OP_ROTX;
      q.sr <= `RBS_SR_RST;
      q.pc <= `RBS_PC_RST;
      q.sp <= `RBS_SP_RST;
    end else begin
      q <= d;
    end
  end

  assign mem = q.mem;
  assign rf = q.rf;
  assign an_we = q.an_we;
  assign an_src = q.an_src;
  assign an_dst = q.an_dst;
  assign pc = q.pc;
  assign stack_pointer = q.sp;
  assign status_word = q.sr;
  assign busy = q.busy;
  assign illegal = q.illegal;
  assign priv_trap = q.priv_trap;
  assign fmt_err = q.fmt_err;
  assign resume = q.resume;

endmodule : rbs_exec

// [rbs_map.svh]
`ifndef RBS_MAP_SVH
`define RBS_MAP_SVH
// Opcode words of the return group
`define RBS_OP_EXC_RET 16'h4e73
`define RBS_OP_DEALLOC 16'h4e74
`define RBS_OP_SUB_RET 16'h4e75
`define RBS_OP_FLAG_RET 16'h4e77
// Fixed upper fields
`define RBS_ROT_TOP 7'h72
`define RBS_DSUB_TOP 4'h8
`define RBS_SETC_TOP 4'h5
// Flag positions in the status word
`define RBS_BIT_C 0
`define RBS_BIT_V 1
`define RBS_BIT_Z 2
`define RBS_BIT_N 3
`define RBS_BIT_X 4
`define RBS_BIT_S 13
// Reset values
`define RBS_SR_RST 16'h2700
`define RBS_PC_RST 32'h00000000
`define RBS_SP_RST 32'h00000000
// Access sizes on the memory port
`define RBS_SZ_BYTE 2'h0
`define RBS_SZ_WORD 2'h1
`define RBS_SZ_LONG 2'h2
// Stack offsets in bytes
`define RBS_OFS_PC 32'h00000002
`define RBS_OFS_FMT 32'h00000006
`define RBS_LEN_PC 32'h00000004
`define RBS_LEN_FLAGRET 32'h00000006
// Frame format codes
`define RBS_FMT_SHORT 4'h0
`define RBS_FMT_THROW 4'h1
`define RBS_FMT_INSTERR 4'h2
`define RBS_FMT_COPRO 4'h9
`define RBS_FMT_MID 4'ha
`define RBS_FMT_LONG 4'hb
// Words removed per format
`define RBS_W_SHORT 6'h04
`define RBS_W_THROW 6'h04
`define RBS_W_INSTERR 6'h06
`define RBS_W_COPRO 6'h0a
`define RBS_W_MID 6'h10
`define RBS_W_LONG 6'h2e
`endif

// [rbs_pkg.sv]
package rbs_pkg;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_RD_SRC = 7'h02,
    ST_RD_OP = 7'h04,
    ST_WR_OP = 7'h08,
    ST_POP_SR = 7'h10,
    ST_POP_PC = 7'h20,
    ST_POP_FMT = 7'h40
  } rbs_st_t;
  typedef enum logic [2:0] {
    OP_ROTX, OP_SETC, OP_DSUB, OP_SUBR, OP_DEALLOC, OP_FLAGS, OP_EXC
  } rbs_op_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rbs_mem_t;
  typedef struct packed {
    logic we;
    logic [2:0] idx;
    logic [7:0] data;
  } rbs_rf_t;
  typedef struct packed {
    rbs_st_t st;
    rbs_op_t op;
    logic [15:0] ir;
    logic [15:0] disp;
    logic [31:0] ea;
    logic [7:0] src;
    logic [15:0] tmp_sr;
    logic [31:0] pc;
    logic [31:0] sp;
    logic [15:0] sr;
    rbs_mem_t mem;
    rbs_rf_t rf;
    logic an_we;
    logic [31:0] an_src;
    logic [31:0] an_dst;
    logic busy;
    logic illegal;
    logic priv_trap;
    logic fmt_err;
    logic resume;
  } rbs_state_t;
endpackage : rbs_pkg

// [rbs_mem_model.sv]
module rbs_mem_model
  import rbs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire rbs_mem_t mem,
  input wire logic [3:0] lat,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] m [256];
  logic [7:0] a;
  logic [3:0] cnt_q;
  logic [31:0] last_q, rd;
  int nb;
  assign a = mem.addr[7:0];
  assign nb = 1 << mem.size;
  // Big-endian bytes, right-aligned on the bus
  always_comb begin
    case (mem.size)
      2'h0: rd = {24'h0, m[a]};
      2'h1: rd = {16'h0, m[a], m[a + 8'h1]};
      default: rd = {m[a], m[a + 8'h1], m[a + 8'h2], m[a + 8'h3]};
    endcase
  end
  ////////////////////////////////////////
  // Idle bus shows the inverse of the last read, never a stale value
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_ack <= 1'b0;
      cnt_q <= 4'h0;
      last_q <= 32'h0;
      mem_rdata <= 32'hffffffff;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~last_q;
      // No ack in the cycle right after an ack
      if (mem.req && !mem_ack && cnt_q >= lat) begin
        cnt_q <= 4'h0;
        mem_ack <= 1'b1;
        mem_rdata <= rd;
        if (mem.we) begin
          for (int i = 0; i < 4; i++) if (i < nb) m[a + 8'(i)] <= mem.wdata[8*(nb-1-i) +: 8];
        end else begin
          last_q <= rd;
        end
      end else if (mem.req && !mem_ack) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule : rbs_mem_model

// [rbs_exec_chk.sv]
module rbs_exec_chk
  import rbs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [31:0] ea_addr,
  input wire rbs_mem_t mem,
  input wire rbs_rf_t rf,
  input wire logic [31:0] stack_pointer,
  input wire logic [15:0] status_word,
  input wire logic busy,
  input wire logic illegal,
  input wire logic priv_trap
);
  timeunit 1ns;
  timeprecision 1ps;
  logic go, rot_w, rot_ok, set_r, dsub_r;
  assign go = instr_valid && !busy;
  assign rot_w = instr_word[15:9] == 7'h72 && instr_word[7:6] == 2'h3;
  assign rot_ok = rot_w && (instr_word[5:3] inside {[3'h2:3'h6]} || instr_word[5:1] == 5'h1c);
  assign set_r = instr_word[15:12] == 4'h5 && instr_word[7:3] == 5'h18;
  assign dsub_r = instr_word[15:12] == 4'h8 && instr_word[8:3] == 6'h20;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  sequence take_s(logic [15:0] w);
    go && instr_word == w;
  endsequence
  // First pop reads at the stack pointer before the op
  sequence pop_s(logic [1:0] sz);
    mem.req && !mem.we && mem.size == sz && mem.addr == $past(stack_pointer);
  endsequence
  sub_ret_pop_a: assert property (take_s(16'h4e75) |=> pop_s(2'h2))
    else $error("subroutine return pop wrong");
  sub_ret_busy_a: assert property (take_s(16'h4e75) |=> busy [*2] ##[1:40] !busy)
    else $error("subroutine return timing wrong");
  dealloc_pop_a: assert property (take_s(16'h4e74) |=> pop_s(2'h2))
    else $error("deallocate pop wrong");
  flag_pop_a: assert property (take_s(16'h4e77) |=> pop_s(2'h1))
    else $error("flag return pop wrong");
  exc_pop_a: assert property (status_word[13] ##0 take_s(16'h4e73) |=> pop_s(2'h1))
    else $error("exception return pop wrong");
  exc_trap_a: assert property (!status_word[13] ##0 take_s(16'h4e73)
    |=> priv_trap && !busy && !mem.req) else $error("user exception return not trapped");
  rot_read_a: assert property (go && rot_ok
    |=> mem.req && !mem.we && mem.size == 2'h1 && mem.addr == $past(ea_addr))
    else $error("rotate read wrong");
  rot_bad_a: assert property (go && rot_w && !rot_ok |=> illegal && !mem.req)
    else $error("bad rotate mode accepted");
  set_reg_a: assert property (go && set_r |=> rf.we && rf.idx == $past(instr_word[2:0])
    && rf.data inside {8'h00, 8'hff} && status_word == $past(status_word))
    else $error("set byte write wrong");
  dsub_reg_a: assert property (go && dsub_r
    |=> rf.we && rf.idx == $past(instr_word[11:9]) && status_word[4] == status_word[0])
    else $error("decimal subtract write wrong");
  rst_val_a: assert property ($rose(rstn) |-> status_word == 16'h2700 && !busy && !mem.req)
    else $error("reset state wrong");
endmodule : rbs_exec_chk

bind rbs_exec rbs_exec_chk u_chk (.clk, .rstn, .instr_valid, .instr_word, .ea_addr, .mem, .rf,
  .stack_pointer, .status_word, .busy, .illegal, .priv_trap);

// [tb_top.sv]
module tb_top
  import rbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] ccr_v [5] = '{16'h000f, 16'h550a, 16'h0005, 16'h0008, 16'h0004};
  localparam logic [15:0] bcd_v [4] = '{16'h4545, 16'h4512, 16'h1245, 16'h5049};
  localparam logic [3:0] fmt_v [8] = '{4'h0, 4'h2, 4'h9, 4'ha, 4'hb, 4'h1, 4'h8, 4'h3};
  localparam int wds_v [8] = '{4, 6, 10, 16, 46, 4, 0, 0};
  localparam logic [15:0] bad_v [4] = '{16'he5c0, 16'he5c8, 16'he5fa, 16'he5fc};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0, instr_ext = 16'h0;
  logic [31:0] ea_addr = 32'h0, reg_src = 32'h0, reg_dst = 32'h0;
  logic [3:0] lat = 4'h1;
  logic mem_ack, an_we, busy, illegal, priv_trap, fmt_err, resume;
  logic [31:0] mem_rdata, an_src, an_dst, pc, stack_pointer, e_sp, e_pc;
  logic [15:0] status_word, e_sr;
  logic [8:0] b;
  rbs_mem_t mem;
  rbs_rf_t rf, rf_s;
  int mismatches = 0, num_checks = 0, n_ill = 0, n_trap = 0, n_fe = 0, n_res = 0;
  int e_res = 0, e_fe = 0, n_anw = 0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (illegal === 1'b1) n_ill++;
    if (priv_trap === 1'b1) n_trap++;
    if (fmt_err === 1'b1) n_fe++;
    if (resume === 1'b1) n_res++;
    if (an_we === 1'b1) n_anw++;
  end
  rbs_exec u_dut (.clk, .rstn, .instr_valid, .instr_word, .instr_ext, .ea_addr, .reg_src,
    .reg_dst, .mem_ack, .mem_rdata, .mem, .rf, .an_we, .an_src, .an_dst, .pc, .stack_pointer,
    .status_word, .busy, .illegal, .priv_trap, .fmt_err, .resume);
  rbs_mem_model u_mem (.clk, .rstn, .mem, .lat, .mem_ack, .mem_rdata);
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  // One instruction; rf captured in the cycle after acceptance
  task automatic op(input logic [15:0] w, input logic [15:0] x);
    int n;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    instr_ext <= x;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    rf_s = rf;
    for (n = 0; n < 500 && busy !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    // Extra edge lets the pulse counters catch up
    @(posedge clk);
    #1;
    if (n == 500) begin
      chk("busy", 32'(busy), 32'h0);
      results();
    end
  endtask : op
  task automatic put(input logic [7:0] a, input logic [31:0] v, input int nb);
    for (int i = 0; i < nb; i++) u_mem.m[a + 8'(i)] = v[8*(nb-1-i) +: 8];
  endtask : put
  task automatic st(input logic [31:0] p);
    chk("pc", pc, p);
    chk("stack_pointer", stack_pointer, e_sp);
    chk("status_word", status_word, e_sr);
  endtask : st
  task automatic frame(input logic [7:0] a, input logic [15:0] s, input logic [31:0] p,
                       input logic [3:0] f);
    put(a, s, 2);
    put(a + 8'h2, p, 4);
    put(a + 8'h6, {f, 12'h018}, 2);
  endtask : frame
  task automatic dfl();
    e_sr[4] = b[8];
    e_sr[0] = b[8];
    if (b[7:0] != 8'h0) e_sr[2] = 1'b0;
    chk("status_word", status_word, e_sr);
  endtask : dfl
  task automatic rot(input logic [15:0] w, input logic [7:0] a, input logic [15:0] din);
    logic [15:0] r;
    logic o;
    if (w[8]) {o, r} = {din, e_sr[4]};
    else {r, o} = {e_sr[4], din};
    put(a, din, 2);
    ea_addr <= {24'h0, a};
    op(w, 16'h0);
    e_sr[4:0] = {o, r[15], r == 16'h0, 1'b0, o};
    chk("rotated word", {u_mem.m[a], u_mem.m[a + 8'h1]}, r);
    chk("status_word", status_word, e_sr);
  endtask : rot
  function automatic logic cond(input logic [3:0] cc, input logic [3:0] f);
    logic n, z, v, c, t;
    {n, z, v, c} = f;
    case (cc[3:1])
      3'h0: t = 1'b1;
      3'h1: t = !c && !z;
      3'h2: t = !c;
      3'h3: t = !z;
      3'h4: t = !v;
      3'h5: t = !n;
      3'h6: t = n == v;
      default: t = n == v && !z;
    endcase
    return t ^ cc[0];
  endfunction : cond
  // Int arithmetic so a negative digit shows up as a borrow
  function automatic logic [8:0] bcd(input logic [7:0] d, input logic [7:0] s, input logic x);
    int lo, hi, bo;
    lo = d[3:0] - s[3:0] - x;
    bo = lo < 0;
    if (bo) lo += 10;
    hi = d[7:4] - s[7:4] - bo;
    if (hi < 0) return {1'b1, 4'(hi + 10), 4'(lo)};
    return {1'b0, 4'(hi), 4'(lo)};
  endfunction : bcd
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    e_sp = 32'h0;
    e_sr = 16'h2700;
    st(32'h0);
    $display("Test reset done");
    foreach (ccr_v[k]) begin
      put(e_sp[7:0], ccr_v[k], 2);
      put(e_sp[7:0] + 8'h2, 32'h100 + k, 4);
      op(16'h4e77, 16'h0);
      e_sp += 6;
      e_sr[7:0] = ccr_v[k][7:0];
      st(32'h100 + k);
      for (int c = 0; c < 16; c++) begin
        op({4'h5, c[3:0], 5'h18, c[2:0]}, 16'h0);
        chk("set byte", rf_s.data, cond(c[3:0], e_sr[3:0]) ? 8'hff : 8'h00);
        chk("status_word", status_word, e_sr);
      end
    end
    $display("Test conditions done");
    foreach (bcd_v[k]) begin
      b = bcd(bcd_v[k][15:8], bcd_v[k][7:0], e_sr[4]);
      reg_dst <= {24'h0, bcd_v[k][15:8]};
      reg_src <= {24'h0, bcd_v[k][7:0]};
      op(16'h8b02, 16'h0);
      chk("decimal result", rf_s.data, b[7:0]);
      dfl();
    end
    put(8'h60, 32'h21, 1);
    put(8'h70, 32'h53, 1);
    reg_src <= 32'h61;
    reg_dst <= 32'h71;
    b = bcd(8'h53, 8'h21, e_sr[4]);
    op(16'h8b0a, 16'h0);
    chk("decimal memory", u_mem.m[8'h70], b[7:0]);
    chk("source address", an_src, 32'h60);
    chk("destination address", an_dst, 32'h70);
    chk("pointer writeback count", n_anw, 1);
    dfl();
    $display("Test decimal done");
    rot(16'he4f8, 8'h42, 16'h0001);
    rot(16'he5d0, 8'h40, 16'h8001);
    rot(16'he5e8, 8'h44, 16'h4000);
    foreach (bad_v[k]) op(bad_v[k], 16'h0);
    chk("illegal count", n_ill, 4);
    ea_addr <= 32'h50;
    put(8'h50, 32'hff, 1);
    op(16'h51d0, 16'h0);
    chk("false byte", u_mem.m[8'h50], 8'h00);
    op(16'h50d0, 16'h0);
    chk("true byte", u_mem.m[8'h50], 8'hff);
    $display("Test memory ops done");
    put(e_sp[7:0], 32'h400, 4);
    op(16'h4e75, 16'h0);
    e_sp += 4;
    st(32'h400);
    for (int k = 0; k < 2; k++) begin
      put(e_sp[7:0], 32'h500 + k, 4);
      op(16'h4e74, k ? 16'hfffc : 16'h0010);
      e_sp += k ? 32'h0 : 32'h14;
      st(32'h500 + k);
    end
    e_pc = 32'h501;
    lat <= 4'h3;
    foreach (fmt_v[k]) begin
      frame(e_sp[7:0], 16'h2710 + k, 32'h600 + k, fmt_v[k]);
      frame(e_sp[7:0] + 8'h8, 16'h2705, 32'h700, 4'h0);
      op(16'h4e73, 16'h0);
      if (wds_v[k] == 0) begin
        e_fe++;
      end else if (fmt_v[k] == 4'h1) begin
        e_sp += 16;
        e_sr = 16'h2705;
        e_pc = 32'h700;
      end else begin
        e_sp += 2 * wds_v[k];
        e_sr = 16'h2710 + k;
        e_pc = 32'h600 + k;
        e_res += fmt_v[k][3];
      end
      st(e_pc);
      chk("resume count", n_res, e_res);
      chk("format errors", n_fe, e_fe);
    end
    frame(e_sp[7:0], 16'h0003, 32'h800, 4'h0);
    op(16'h4e73, 16'h0);
    e_sp += 8;
    e_sr = 16'h0003;
    st(32'h800);
    op(16'h4e73, 16'h0);
    chk("trap count", n_trap, 1);
    st(32'h800);
    $display("Test returns done");
    results();
  end
endmodule : tb_top
